// >>> src/port_alt_function_and_input.sv
// Contract
// [R1] set-two sub-register visible only when selector 08H
// [R2] set-two resets 00H; small-package port A 04H
// [R3] input value registers read-only, sampled pin levels
// [R4] absent pins read as zero
// [R5] port A: enable alone connects fixed function
// [R6] set bits choose function only when enabled
// [R7] PA0/PA6 timer input or inverted output
// [R8] large-package port A function map
// [R9] software sets clock-input function, then oscillator
// [R10] pins pass two-stage synchroniser before reads
`default_nettype none
module port_alt_function_and_input (
	input wire logic clk,
	input wire logic reset,
	input wire logic smallPackage,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [11:0] regAddr,
	input wire logic [7:0] regWriteData,
	output logic [7:0] regReadData,
	input wire logic [7:0] portAPins,
	input wire logic [7:0] portBPins,
	input wire logic [7:0] portCPins,
	input wire logic [7:0] portAData,
	input wire logic timerZeroOutput,
	input wire logic timerOneOutput,
	input wire logic timerZeroInputMode,
	input wire logic timerOneInputMode,
	input wire logic serialDriverEnable,
	input wire logic serialTransmitLine,
	output logic [7:0] portAOut,
	output logic [7:0] portAAltActive,
	output logic timerZeroInput,
	output logic timerOneInput,
	output logic serialClearToSend,
	output logic serialReceiveLine,
	output logic externalClockInput,
	output logic [7:0] altSelectOneBits,
	output logic [7:0] altSelectTwoBits
);
	localparam int N = port_af_pkg::NUM_PORTS;

	logic [7:0] subAddr_r [N];
	logic [7:0] subAddr_nxt [N];
	logic [7:0] altEnable_r [N];
	logic [7:0] altEnable_nxt [N];
	logic [7:0] selOne_r [N];
	logic [7:0] selOne_nxt [N];
	logic [7:0] selTwo_r [N];
	logic [7:0] selTwo_nxt [N];
	logic [7:0] readData_r;
	logic [7:0] readData_nxt;
	logic [7:0] syncA;
	logic [7:0] syncB;
	logic [7:0] syncC;
	logic [7:0] presentA;
	logic [7:0] presentBC;
	logic [7:0] maskedIn [N];
	logic [7:0] ctlRead [N];
	logic [N-1:0] hitSub;
	logic [N-1:0] hitCtl;
	logic [7:0] twoResetA;

	// ==========================================================
	// pin synchronisers, one per port
	pin_sync syncPortA (
		.clk(clk),
		.reset(reset),
		.pinsIn(portAPins),
		.pinsOut(syncA)
	);
	pin_sync syncPortB (
		.clk(clk),
		.reset(reset),
		.pinsIn(portBPins),
		.pinsOut(syncB)
	);
	pin_sync syncPortC (
		.clk(clk),
		.reset(reset),
		.pinsIn(portCPins),
		.pinsOut(syncC)
	);

	// ==========================================================
	// package masks; absent pins never leak a level
	assign presentA = smallPackage ? port_af_pkg::SMALL_A_PRESENT
		: port_af_pkg::LARGE_PRESENT;
	assign presentBC = smallPackage ? port_af_pkg::SMALL_BC_PRESENT
		: port_af_pkg::LARGE_PRESENT;
	assign maskedIn[0] = syncA & presentA; // R4
	assign maskedIn[1] = syncB & presentBC; // R4
	assign maskedIn[2] = syncC & presentBC; // R4
	assign twoResetA = smallPackage ? port_af_pkg::ALT_TWO_RESET_SMALL_A
		: port_af_pkg::ALT_TWO_RESET;

	// ==========================================================
	// per-port address decode and sub-register storage
	genvar p;
	generate
		for (p = 0; p < N; p++)
		begin : gPort
			localparam logic [11:0] OFS = 12'(p * 4);
			assign hitSub[p] = regAddr == port_af_pkg::PORT_A_SUBADDR_ADDR + OFS;
			assign hitCtl[p] = regAddr == port_af_pkg::PORT_A_CONTROL_ADDR + OFS;

			// control register shows the selected sub-register
			always_comb
			begin
				unique case (subAddr_r[p])
					port_af_pkg::SUB_ALT_ENABLE: ctlRead[p] = altEnable_r[p];
					port_af_pkg::SUB_ALT_SEL_ONE: ctlRead[p] = selOne_r[p];
					port_af_pkg::SUB_ALT_SEL_TWO: ctlRead[p] = selTwo_r[p]; // R1
					default: ctlRead[p] = port_af_pkg::ZERO_BYTE;
				endcase
			end

			// next values of address and sub-registers
			always_comb
			begin
				subAddr_nxt[p] = subAddr_r[p];
				altEnable_nxt[p] = altEnable_r[p];
				selOne_nxt[p] = selOne_r[p];
				selTwo_nxt[p] = selTwo_r[p];
				if (regWrite && hitSub[p])
					subAddr_nxt[p] = regWriteData;
				if (regWrite && hitCtl[p])
				begin
					if (subAddr_r[p] == port_af_pkg::SUB_ALT_ENABLE)
						altEnable_nxt[p] = regWriteData;
					// port A has no set-one register: its writes dropped
					if (p != 0 && subAddr_r[p] == port_af_pkg::SUB_ALT_SEL_ONE)
						selOne_nxt[p] = regWriteData; // R5
					if (subAddr_r[p] == port_af_pkg::SUB_ALT_SEL_TWO)
						selTwo_nxt[p] = regWriteData; // R1
				end
			end

			always_ff @(posedge clk)
			begin
				if (reset)
				begin
					subAddr_r[p] <= port_af_pkg::ZERO_BYTE;
					altEnable_r[p] <= port_af_pkg::ZERO_BYTE;
					selOne_r[p] <= port_af_pkg::ZERO_BYTE;
					selTwo_r[p] <= (p == 0) ? twoResetA
						: port_af_pkg::ALT_TWO_RESET; // R2
				end
				else
				begin
					subAddr_r[p] <= subAddr_nxt[p];
					altEnable_r[p] <= altEnable_nxt[p];
					selOne_r[p] <= selOne_nxt[p];
					selTwo_r[p] <= selTwo_nxt[p];
				end
			end
		end
	endgenerate

	// ==========================================================
	// read mux; input registers ignore writes entirely
	always_comb
	begin
		readData_nxt = readData_r;
		if (regRead)
		begin
			readData_nxt = port_af_pkg::ZERO_BYTE;
			if (regAddr == port_af_pkg::PORT_A_INPUT_ADDR)
				readData_nxt = maskedIn[0]; // R3
			else if (regAddr == port_af_pkg::PORT_B_INPUT_ADDR)
				readData_nxt = maskedIn[1]; // R3
			else if (regAddr == port_af_pkg::PORT_C_INPUT_ADDR)
				readData_nxt = maskedIn[2]; // R3
			else
				for (int i = 0; i < N; i++)
				begin
					if (hitSub[i])
						readData_nxt = subAddr_r[i];
					if (hitCtl[i])
						readData_nxt = ctlRead[i];
				end
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			readData_r <= port_af_pkg::ZERO_BYTE;
		else
			readData_r <= readData_nxt;
	end

	assign regReadData = readData_r;

	// ==========================================================
	// port A fixed mapping: enable bit alone selects function
	always_comb
	begin
		portAOut = portAData;
		portAAltActive = altEnable_r[0] & presentA; // R5 R6
		// timer pins: input mode leaves pad undriven, else complement
		if (altEnable_r[0][port_af_pkg::PA_TIMER0_IO])
		begin
			portAOut[port_af_pkg::PA_TIMER0_IO] = ~timerZeroOutput; // R7
			portAAltActive[port_af_pkg::PA_TIMER0_IO] = !timerZeroInputMode;
		end
		if (altEnable_r[0][port_af_pkg::PA_TIMER1_IO])
		begin
			portAOut[port_af_pkg::PA_TIMER1_IO] = ~timerOneOutput; // R7
			portAAltActive[port_af_pkg::PA_TIMER1_IO] = !timerOneInputMode
				&& !smallPackage;
		end
		// on the small package PA1 is the clock input, not an output
		if (altEnable_r[0][port_af_pkg::PA_TIMER0_OUT])
		begin
			portAOut[port_af_pkg::PA_TIMER0_OUT] = timerZeroOutput; // R8
			if (smallPackage)
				portAAltActive[port_af_pkg::PA_TIMER0_OUT] = 1'b0;
		end
		if (altEnable_r[0][port_af_pkg::PA_SER_DE])
			portAOut[port_af_pkg::PA_SER_DE] = serialDriverEnable; // R8
		if (altEnable_r[0][port_af_pkg::PA_SER_TX])
			portAOut[port_af_pkg::PA_SER_TX] = serialTransmitLine; // R8
		if (altEnable_r[0][port_af_pkg::PA_TIMER1_OUT])
			portAOut[port_af_pkg::PA_TIMER1_OUT] = timerOneOutput; // R8
		// input pins are never driven
		portAAltActive[port_af_pkg::PA_SER_CTS] = 1'b0;
		portAAltActive[port_af_pkg::PA_SER_RX] = 1'b0;
		// unclaimed pads keep port data, so a timer pin left in input
		// mode or an absent pad never shows a stray peripheral level
		portAOut = (portAOut & portAAltActive)
			| (portAData & ~portAAltActive); // R6
	end

	// ==========================================================
	// inputs toward peripherals; idle levels when not selected
	assign timerZeroInput = altEnable_r[0][port_af_pkg::PA_TIMER0_IO]
		&& timerZeroInputMode && maskedIn[0][port_af_pkg::PA_TIMER0_IO]; // R7
	assign timerOneInput = altEnable_r[0][port_af_pkg::PA_TIMER1_IO]
		&& timerOneInputMode && maskedIn[0][port_af_pkg::PA_TIMER1_IO]; // R7
	// idle high: clear-to-send is active low, receive line idles high
	assign serialClearToSend = !altEnable_r[0][port_af_pkg::PA_SER_CTS]
		|| maskedIn[0][port_af_pkg::PA_SER_CTS]; // R8
	assign serialReceiveLine = !altEnable_r[0][port_af_pkg::PA_SER_RX]
		|| maskedIn[0][port_af_pkg::PA_SER_RX]; // R8

	// external clock pin: PA1 on small package, else PB3 (software
	// must enable this before switching the oscillator source)
	assign externalClockInput = smallPackage
		? (altEnable_r[0][port_af_pkg::PA_TIMER0_OUT]
			&& syncA[port_af_pkg::PA_TIMER0_OUT])
		: (altEnable_r[1][port_af_pkg::PB_CLOCK_IN]
			&& syncB[port_af_pkg::PB_CLOCK_IN]); // R9

	// set bits go out gated by enable, port B copy shown
	assign altSelectOneBits = selOne_r[1] & altEnable_r[1]; // R6
	assign altSelectTwoBits = selTwo_r[1] & altEnable_r[1]; // R6
endmodule : port_alt_function_and_input
`default_nettype wire

// >>> src/port_af_pkg.sv
`default_nettype none
package port_af_pkg;
	// ==========================================================
	// register file addresses (12-bit register space)
	localparam logic [11:0] PORT_A_INPUT_ADDR = 12'hFD2;
	localparam logic [11:0] PORT_B_INPUT_ADDR = 12'hFD6;
	localparam logic [11:0] PORT_C_INPUT_ADDR = 12'hFDA;
	// ==========================================================
	// port address / control pair per port (A at base, B +4, C +8)
	localparam logic [11:0] PORT_A_SUBADDR_ADDR = 12'hFD0;
	localparam logic [11:0] PORT_A_CONTROL_ADDR = 12'hFD1;
	localparam logic [11:0] PORT_STRIDE = 12'h004;
	// ==========================================================
	// sub-register selectors written to the port address register
	localparam logic [7:0] SUB_ALT_ENABLE = 8'h02;
	localparam logic [7:0] SUB_ALT_SEL_ONE = 8'h07;
	localparam logic [7:0] SUB_ALT_SEL_TWO = 8'h08;
	// ==========================================================
	// reset values
	localparam logic [7:0] ALT_TWO_RESET = 8'h00;
	localparam logic [7:0] ALT_TWO_RESET_SMALL_A = 8'h04;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	// ==========================================================
	// pins present per package: small package has six port A pins
	localparam logic [7:0] SMALL_A_PRESENT = 8'h3F;
	localparam logic [7:0] SMALL_BC_PRESENT = 8'h00;
	localparam logic [7:0] LARGE_PRESENT = 8'hFF;
	localparam int NUM_PORTS = 3;
	// ==========================================================
	// port A bit positions of fixed functions, then the port B clock input
	localparam int PA_TIMER0_IO = 0;
	localparam int PA_TIMER0_OUT = 1;
	localparam int PA_SER_DE = 2;
	localparam int PA_SER_CTS = 3;
	localparam int PA_SER_RX = 4;
	localparam int PA_SER_TX = 5;
	localparam int PA_TIMER1_IO = 6;
	localparam int PA_TIMER1_OUT = 7;
	localparam int PB_CLOCK_IN = 3;
endpackage : port_af_pkg
`default_nettype wire

// >>> src/pin_sync.sv
`default_nettype none
module pin_sync (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] pinsIn,
	output logic [7:0] pinsOut
);
	logic [7:0] stageOne_r;
	logic [7:0] stageOne_nxt;
	logic [7:0] stageTwo_r;
	logic [7:0] stageTwo_nxt;

	// ==========================================================
	// two flops; first stage feeds only the second
	always_comb
	begin
		stageOne_nxt = pinsIn;
		stageTwo_nxt = stageOne_r;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			stageOne_r <= port_af_pkg::ZERO_BYTE;
			stageTwo_r <= port_af_pkg::ZERO_BYTE;
		end
		else
		begin
			stageOne_r <= stageOne_nxt;
			stageTwo_r <= stageTwo_nxt; // R10
		end
	end

	assign pinsOut = stageTwo_r;
endmodule : pin_sync
`default_nettype wire

// >>> sim/port_af_props.sv
`default_nettype none
module port_af_props (
	input wire logic clk,
	input wire logic reset,
	input wire logic smallPackage,
	input wire logic regRead,
	input wire logic [11:0] regAddr,
	input wire logic [7:0] regReadData,
	input wire logic [7:0] portAPins,
	input wire logic [7:0] portBPins,
	input wire logic [7:0] portAData,
	input wire logic timerZeroOutput,
	input wire logic timerZeroInputMode,
	input wire logic [7:0] portAOut,
	input wire logic [7:0] portAAltActive,
	input wire logic timerZeroInput,
	input wire logic serialReceiveLine,
	input wire logic externalClockInput
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// reads; one clock, so one default for all
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	a_read_holds: assert property (!regRead |=> $stable(regReadData))
		else $error("read data moved");
	a_pin_read: assert property ($stable(portAPins)[*2] ##0
		(regRead && !smallPackage && !$past(reset, 2) &&
		regAddr == port_af_pkg::PORT_A_INPUT_ADDR)
		|=> regReadData == $past(portAPins)) else $error("bad pin read");
	a_absent_zero: assert property (regRead && smallPackage &&
		regAddr == port_af_pkg::PORT_B_INPUT_ADDR |=> regReadData == 8'h00)
		else $error("absent port not zero");
	// ==========
	// pads: levels arrive two edges late, behind the sync flops
	a_timer_input: assert property (timerZeroInput |->
		timerZeroInputMode && $past(portAPins[0], 2)) else $error("timer in");
	a_rx_idle: assert property (!serialReceiveLine |->
		!$past(portAPins[4], 2)) else $error("receive low");
	a_clock_pin: assert property (externalClockInput |-> (smallPackage ?
		$past(portAPins[1], 2) : $past(portBPins[3], 2))) else $error("clock");
	a_gpio_data: assert property ((portAOut & ~portAAltActive) ==
		(portAData & ~portAAltActive)) else $error("pad not gpio data");
	a_inverted_out: assert property (portAAltActive[0] &&
		!timerZeroInputMode |-> portAOut[0] == !timerZeroOutput)
		else $error("timer zero pad");
endmodule : port_af_props
bind port_alt_function_and_input port_af_props props (.*);
`default_nettype wire

// >>> sim/pin_world.sv
`default_nettype none
module pin_world (
	input wire logic clk,
	input wire logic smallPackage,
	input wire logic load,
	input wire logic [31:0] pattern,
	output logic [7:0] portAPins,
	output logic [7:0] portBPins,
	output logic [7:0] portCPins,
	output logic timerZeroOutput,
	output logic timerOneOutput,
	output logic serialDriverEnable,
	output logic serialTransmitLine
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [27:0] held = 28'h0000000;
	logic flip = 1'b0;
	// ==========
	// present pads move only on a load, so reads see settled pads
	always @(posedge clk)
	begin
		flip <= ~flip;
		if (load)
			held <= pattern[27:0];
	end
	// missing pads float: a toggling pattern, never a steady level
	assign portAPins = smallPackage ? {{2{flip}}, held[5:0]} : held[7:0];
	assign portBPins = smallPackage ? {8{flip}} : held[15:8];
	assign portCPins = smallPackage ? {8{~flip}} : held[23:16];
	assign {serialTransmitLine, serialDriverEnable} = held[27:26];
	assign {timerOneOutput, timerZeroOutput} = held[25:24];
endmodule : pin_world
`default_nettype wire

// >>> sim/port_alt_function_and_input_bench.sv
`default_nettype none
module port_alt_function_and_input_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, reset = 1'b1, smallPackage = 1'b0, load = 1'b0;
	logic regWrite = 1'b0, regRead = 1'b0, pend = 1'b0;
	logic timerZeroInputMode = 1'b0, timerOneInputMode = 1'b0;
	logic [11:0] regAddr = 12'h000;
	logic [7:0] regWriteData = 8'h00, portAData = 8'h00, msk, e, ins;
	logic [7:0] regReadData, portAPins, portBPins, portCPins, portAOut;
	logic [7:0] portAAltActive, altSelectOneBits, altSelectTwoBits;
	logic timerZeroOutput, timerOneOutput, serialDriverEnable;
	logic serialTransmitLine, timerZeroInput, timerOneInput;
	logic serialClearToSend, serialReceiveLine, externalClockInput;
	logic [31:0] pattern = 32'h00000000, pat;
	logic [7:0] q[$];
	int n_mismatch = 0, checked = 0, cycles = 0, seed = 63;
	// ==========
	// block, pads and peripherals
	port_alt_function_and_input dut (.*);
	pin_world world (.*);
	assign ins = {4'h0, timerZeroInput, timerOneInput, serialClearToSend,
		serialReceiveLine};
	always #2 clk = ~clk;
	// reads answer at the taking edge; compare half a cycle on
	always @(posedge clk)
	begin
		pend <= regRead && !reset;
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			n_mismatch++;
			final_report();
		end
	end
	always @(negedge clk)
		if (pend)
			check("read", regReadData, q.pop_front());
	task automatic check(input string what, input logic [7:0] seen, ex);
		checked++;
		if (seen !== ex)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, ex, seen);
		end
	endtask : check
	// one access per edge, back to back; a read notes its byte
	task automatic op(input logic w, r, input logic [11:0] a,
		input logic [7:0] d);
		@(posedge clk);
		regWrite <= w;
		regRead <= r;
		regAddr <= a;
		regWriteData <= d;
		if (r)
			q.push_back(d);
	endtask : op
	// bus idle, new pad levels, then time to cross both sync flops
	task automatic pins;
		pat = $random(seed);
		@(posedge clk);
		{regWrite, regRead, load} <= 3'h1;
		pattern <= pat;
		portAData <= pat[31:24];
		@(posedge clk);
		load <= 1'b0;
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask : pins
	task automatic final_report;
		if (n_mismatch == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report
	// ==========
	// small package first, then the full one
	initial
	begin
		for (int pk = 1; pk >= 0; pk--)
		begin
			@(posedge clk);
			{reset, smallPackage} <= {1'b1, pk[0]};
			repeat (20) @(posedge clk);
			reset <= 1'b0;
			op(1'b1, 1'b0, 12'hFD0, 8'h08);
			op(1'b0, 1'b1, 12'hFD1, pk ? 8'h04 : 8'h00);
			msk = pk ? 8'h3F : 8'hFF;
			repeat (5)
			begin
				pins();
				op(1'b1, 1'b0, 12'hFD2, ~pat[7:0]);
				op(1'b0, 1'b1, 12'hFD2, pat[7:0] & msk);
				op(1'b0, 1'b1, 12'hFD6, pk ? 8'h00 : pat[15:8]);
				op(1'b0, 1'b1, 12'hFDA, pk ? 8'h00 : pat[23:16]);
			end
			// clock pad is A1 on the small package, B3 otherwise
			op(1'b1, 1'b0, 12'hFD0, 8'h02);
			op(1'b1, 1'b0, 12'hFD1, 8'h02);
			op(1'b1, 1'b0, 12'hFD4, 8'h02);
			op(1'b1, 1'b0, 12'hFD5, 8'h08);
			pins();
			e = 8'(pk ? pat[1] : pat[11]);
			check("clock", 8'(externalClockInput), e);
		end
		// set-two of port B is reached only under selector 08
		op(1'b1, 1'b0, 12'hFD4, 8'h08);
		op(1'b1, 1'b0, 12'hFD5, 8'h5A);
		op(1'b0, 1'b1, 12'hFD5, 8'h5A);
		op(1'b1, 1'b0, 12'hFD4, 8'h07);
		op(1'b0, 1'b1, 12'hFD5, 8'h00);
		op(1'b1, 1'b0, 12'hFD0, 8'h07);
		op(1'b1, 1'b0, 12'hFD1, 8'h33);
		op(1'b0, 1'b1, 12'hFD1, 8'h00);
		op(1'b1, 1'b0, 12'hFD0, 8'h02);
		for (int k = 0; k < 4; k++)
		begin
			op(1'b1, 1'b0, 12'hFD1, k[1] ? 8'hFF : 8'h00);
			{timerZeroInputMode, timerOneInputMode} <= {2{k[0]}};
			pins();
			check("set1", altSelectOneBits, 8'h00);
			check("set2", altSelectTwoBits, 8'h08);
			msk = !k[1] ? 8'hFF : k[0] ? 8'hA6 : 8'hE7;
			e = !k[1] ? pat[31:24] : {pat[25], ~pat[25], pat[27], 2'h0,
				pat[26], pat[24], ~pat[24]};
			check("pad", portAOut & msk, e & msk);
			e = !k[1] ? 8'h03 : {4'h0, pat[0] & k[0], pat[6] & k[0], pat[4:3]};
			check("inputs", {ins[7:2], ins[0], ins[1]}, e);
		end
		final_report();
	end
endmodule : port_alt_function_and_input_bench
`default_nettype wire
